// >>> core/shift_ops_exec.sv
`timescale 1ns/1ps
`include "shift_ops_defines.svh"

// Notes on behaviour
// RULE1: Mantissa load keeps destination exponent unchanged.
// RULE2: Memory source loads whole word as mantissa.
// RULE3: Immediate mantissa load has bits 15-12 zero.
// RULE4: Page load is an immediate unsigned load.
// RULE5: Page load writes source bits into pointer.
// RULE6: Direct address uses pointer page, 64K words.
// RULE7: Software keeps pointer bits 31-8 zero.
// RULE8: Slow mode runs at input clock over 16.
// RULE9: Slowdown starts in the slow instruction itself.
// RULE10: Full-rate instruction restores rate immediately.
// RULE11: Software avoids deep idle in slow mode.
// RULE12: Count is low seven bits, signed.
// RULE13: Positive count shifts left, zero fill.
// RULE14: Negative count shifts right logically, zero fill.
// RULE15: Zero count leaves operand, clears carry.
// RULE16: Three-operand shift writes copy to destination.
// RULE17: Two-operand mode field selects count source.
// RULE18: Three-operand field selects source and count.
// RULE19: Overflow mode bit never changes results.
// RULE20: Carry takes last bit shifted out.
// RULE21: Shift flags update only for extended registers.
// RULE22: Single cycle; loads and power ops keep flags.
module shift_ops_exec
  import shift_ops_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_clk_en,
  // Decoded instruction.
  input  wire exec_req_t            i_req,
  input  wire logic [`IMM_W-1:0]    i_direct_disp,
  // Register file write.
  output logic                      o_wr_valid,
  output logic [`IDX_W-1:0]         o_wr_idx,
  output logic [`EXT_W-1:0]         o_wr_data,
  // Status.
  output cond_flags_t               o_flags,
  output logic [`WORD_W-1:0]        o_page_ptr,
  output logic [`PAGE_W+`IMM_W-1:0] o_direct_addr,
  output logic                      o_slow_mode,
  output logic                      o_cycle_tick
);

  // ***************************************************************
  // Instruction acceptance
  // ***************************************************************

  logic                     accept;
  logic                     is_shift;
  logic [`WORD_W-1:0]       shift_in;
  logic [`WORD_W-1:0]       cnt_word;
  logic signed [`CNT_W-1:0] cnt;
  logic [`CNT_W-1:0]        cnt_mag;
  logic [2*`WORD_W-1:0]     shift_ext;
  logic [`WORD_W-1:0]       shift_res;
  logic                     shift_carry;
  logic [`WORD_W-1:0]       mant_val;
  logic                     slow_d;
  logic [`DIV_W-1:0]        div_q;
  logic [`DIV_W-1:0]        div_d;

  // An instruction is taken only on an instruction-cycle tick, one per tick.
  assign accept   = i_clk_en && i_req.valid && o_cycle_tick; // RULE22
  assign is_shift = (i_req.op == logical_shift_op) || (i_req.op == three_operand_shift_op);

  // ***************************************************************
  // Operand selection
  // ***************************************************************

  // Picks the shifted operand, the count word and the mantissa source.
  always_comb
  begin
    shift_in = i_req.reg_dst[`WORD_W-1:0];
    cnt_word = i_req.reg_cnt[`WORD_W-1:0];
    mant_val = i_req.reg_src[`WORD_W-1:0]; // RULE1
    if (i_req.op == three_operand_shift_op)
    begin
      // Bit 0 of the mode picks the source, bit 1 the count.
      shift_in = i_req.mode[0] ? i_req.mem_src : i_req.reg_src[`WORD_W-1:0]; // RULE18 RULE16
      cnt_word = i_req.mode[1] ? i_req.mem_cnt : i_req.reg_cnt[`WORD_W-1:0]; // RULE18
    end
    else
    begin
      case (i_req.mode)
        `MODE_REG:      cnt_word = i_req.reg_cnt[`WORD_W-1:0]; // RULE17
        `MODE_DIRECT:   cnt_word = i_req.mem_cnt;               // RULE17
        `MODE_INDIRECT: cnt_word = i_req.mem_cnt;               // RULE17
        `MODE_IMM:      cnt_word = {{(`WORD_W-`IMM_W){1'b0}}, i_req.imm}; // RULE17
        default:        cnt_word = i_req.reg_cnt[`WORD_W-1:0];
      endcase
    end
    case (i_req.mode)
      `MODE_DIRECT,
      `MODE_INDIRECT: mant_val = i_req.mem_src; // RULE2
      `MODE_IMM:      mant_val = {i_req.imm[`IMM_SIGN_BIT], i_req.imm[`IMM_FRAC_MSB:0], {`IMM_PAD_W{1'b0}}};
      default:        mant_val = i_req.reg_src[`WORD_W-1:0];
    endcase
  end

  // ***************************************************************
  // Barrel shifter
  // ***************************************************************

  // The low seven bits form a signed count; the operand is unsigned.
  assign cnt     = signed'(cnt_word[`CNT_W-1:0]); // RULE12
  assign cnt_mag = cnt[`CNT_W-1] ? `CNT_W'(-cnt) : `CNT_W'(cnt);

  // Shifts inside a double-width word so the last bit out lands next to the result.
  always_comb
  begin
    shift_ext   = {{`WORD_W{1'b0}}, shift_in};
    shift_res   = shift_in;
    shift_carry = 1'b0; // RULE15
    if (cnt[`CNT_W-1])
    begin
      shift_ext   = {shift_in, {`WORD_W{1'b0}}} >> cnt_mag; // RULE14
      shift_res   = shift_ext[2*`WORD_W-1:`WORD_W];
      shift_carry = shift_ext[`WORD_W-1]; // RULE20
    end
    else if (cnt != '0)
    begin
      shift_ext   = {{`WORD_W{1'b0}}, shift_in} << cnt_mag; // RULE13
      shift_res   = shift_ext[`WORD_W-1:0];
      shift_carry = shift_ext[`WORD_W]; // RULE20
    end
  end

  // ***************************************************************
  // Register file write and flags
  // ***************************************************************

  // Results ignore the overflow mode bit; no such input exists here.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_wr_valid <= 1'b0;
      o_wr_idx   <= '0;
      o_wr_data  <= '0;
    end
    else if (i_clk_en)
    begin
      o_wr_valid <= accept && (is_shift || (i_req.op == mantissa_load_op)); // RULE19
      if (accept && (i_req.op == mantissa_load_op))
      begin
        o_wr_idx  <= i_req.dst_idx;
        o_wr_data <= {i_req.reg_dst[`EXT_W-1:`EXP_LSB], mant_val}; // RULE1 RULE2
      end
      else if (accept && is_shift)
      begin
        o_wr_idx  <= i_req.dst_idx;
        o_wr_data <= {i_req.reg_dst[`EXT_W-1:`EXP_LSB], shift_res}; // RULE16
      end
    end
  end

  // Shift flags change only for the extended-precision group; other ops leave them.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_flags <= '0;
    else if (i_clk_en && accept && is_shift && (i_req.dst_idx < `EXT_REG_COUNT)) // RULE21 RULE22
    begin
      o_flags.uf <= 1'b0;
      o_flags.v  <= 1'b0;
      o_flags.n  <= shift_res[`WORD_W-1];
      o_flags.z  <= (shift_res == '0);
      o_flags.c  <= shift_carry; // RULE20 RULE15
    end
  end

  // ***************************************************************
  // Data page pointer
  // ***************************************************************

  // The page load is an immediate load of address bits 23-16 into the low byte.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_page_ptr <= `DP_RESET;
    else if (i_clk_en && accept && (i_req.op == page_pointer_load_op))
      o_page_ptr <= {{(`WORD_W-`PAGE_W){1'b0}}, i_req.imm[`PAGE_SRC_MSB:0]}; // RULE4 RULE5
  end

  // Direct addresses are the page byte over a 64K-word offset.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_direct_addr <= '0;
    else if (i_clk_en)
      o_direct_addr <= {o_page_ptr[`PAGE_W-1:0], i_direct_disp}; // RULE6
  end

  // ***************************************************************
  // Instruction-rate control
  // ***************************************************************

  // Mode changes take effect in the cycle the instruction is taken.
  always_comb
  begin
    slow_d = o_slow_mode;
    if (accept && (i_req.op == slow_clock_op))
      slow_d = 1'b1; // RULE9
    else if (accept && (i_req.op == full_rate_op))
      slow_d = 1'b0; // RULE10
    div_d = '0;
    if (slow_d)
      div_d = accept ? '0 : div_q + 1'b1;
  end

  // One tick in sixteen while slow; every cycle otherwise.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_slow_mode  <= 1'b0;
      div_q        <= '0;
      o_cycle_tick <= 1'b1;
    end
    else if (i_clk_en)
    begin
      o_slow_mode  <= slow_d;
      div_q        <= div_d;
      o_cycle_tick <= !slow_d || (div_d == `DIV_LAST); // RULE8 RULE10
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Shifter results, carry and written data.
  zero_count_carry_a: assert property (accept && is_shift && (cnt == '0)
    && (i_req.dst_idx < `EXT_REG_COUNT) |=> !o_flags.c && (o_wr_data[`WORD_W-1:0] == $past(shift_in))) // RULE15
    else $error("zero count did not clear carry or altered operand");
  left_fill_a: assert property (accept && is_shift && !cnt[`CNT_W-1] && (cnt != '0)
    |=> (o_wr_data[0] == 1'b0)) // RULE13
    else $error("left shift did not zero-fill");
  right_fill_a: assert property (accept && is_shift && cnt[`CNT_W-1]
    |=> (o_wr_data[`WORD_W-1] == 1'b0)) // RULE14
    else $error("right shift did not zero-fill");
  shift_write_a: assert property (accept && is_shift
    |=> o_wr_valid && (o_wr_idx == $past(i_req.dst_idx))) // RULE16 RULE22
    else $error("shift result not written to its destination");
  left_one_carry_a: assert property (accept && is_shift && (cnt_mag == `CNT_W'(1'b1)) && !cnt[`CNT_W-1]
    && (i_req.dst_idx < `EXT_REG_COUNT) |=> (o_flags.c == $past(shift_in[`WORD_W-1]))) // RULE20
    else $error("left shift carry is not the top bit shifted out");

  // Mantissa load results.
  mant_exp_keep_a: assert property (accept && (i_req.op == mantissa_load_op)
    |=> o_wr_valid && (o_wr_data[`EXT_W-1:`EXP_LSB] == $past(i_req.reg_dst[`EXT_W-1:`EXP_LSB]))) // RULE1
    else $error("mantissa load changed exponent");
  mant_imm_a: assert property (accept && (i_req.op == mantissa_load_op) && (i_req.mode == `MODE_IMM)
    |=> (o_wr_data[`IMM_PAD_W-1:0] == '0) && (o_wr_data[`WORD_W-1] == $past(i_req.imm[`IMM_SIGN_BIT]))) // RULE1
    else $error("immediate mantissa not placed at the top of the word");

  // Condition flags.
  load_flags_keep_a: assert property (accept && !is_shift |=> $stable(o_flags)) // RULE22
    else $error("non-shift op changed flags");
  ext_flags_only_a: assert property (accept && is_shift && (i_req.dst_idx >= `EXT_REG_COUNT)
    |=> $stable(o_flags)) // RULE21
    else $error("flags changed for non-extended destination");
  neg_flag_a: assert property (accept && is_shift && (i_req.dst_idx < `EXT_REG_COUNT)
    |=> (o_flags.n == o_wr_data[`WORD_W-1]) && (o_flags.z == (o_wr_data[`WORD_W-1:0] == '0))) // RULE21
    else $error("negative or zero flag wrong");
  latch_flags_keep_a: assert property (accept && is_shift |=> $stable({o_flags.latched_underflow_flag, o_flags.lv})) // RULE21
    else $error("shift changed a latched flag");

  // Page pointer.
  page_load_a: assert property (accept && (i_req.op == page_pointer_load_op)
    |=> (o_page_ptr == {{(`WORD_W-`PAGE_W){1'b0}}, $past(i_req.imm[`PAGE_SRC_MSB:0])})) // RULE5
    else $error("page pointer not loaded");
  page_hold_a: assert property (!(accept && (i_req.op == page_pointer_load_op))
    |=> $stable(o_page_ptr)) // RULE4
    else $error("page pointer changed without a page load");

  // Instruction-rate control.
  slow_gap_a: assert property (accept && (i_req.op == slow_clock_op) ##1 i_clk_en [*8]
    |-> !o_cycle_tick) // RULE9
    else $error("tick came too early in slow mode");
  slow_period_a: assert property (accept && (i_req.op == slow_clock_op) ##1 i_clk_en [*8] ##1 i_clk_en [*8]
    |-> o_cycle_tick) // RULE8
    else $error("slow tick not every sixteen cycles");
  full_resume_a: assert property (accept && (i_req.op == full_rate_op) |=> o_cycle_tick && !o_slow_mode) // RULE10
    else $error("full rate did not resume");
  fast_tick_a: assert property (!o_slow_mode |-> o_cycle_tick) // RULE8 RULE10
    else $error("slot missing while at full rate");

  // Main scenarios the bench should reach.
  shift_left_c: cover property (accept && is_shift && !cnt[`CNT_W-1] && (cnt != '0));
  shift_right_c: cover property (accept && is_shift && cnt[`CNT_W-1]);
  slow_then_full_c: cover property (accept && (i_req.op == slow_clock_op) ##[1:40]
    (accept && (i_req.op == full_rate_op)));
  mant_mem_c: cover property (accept && (i_req.op == mantissa_load_op) && (i_req.mode == `MODE_INDIRECT));
  page_load_c: cover property (accept && (i_req.op == page_pointer_load_op));

endmodule

// >>> core/shift_ops_defines.svh
`ifndef SHIFT_OPS_DEFINES_SVH
`define SHIFT_OPS_DEFINES_SVH

// Data path widths.
`define WORD_W        32
`define EXT_W         40
`define EXP_LSB       32
`define IMM_W         16
`define IDX_W         5
// Short immediate float: sign bit and fraction field.
`define IMM_SIGN_BIT  11
`define IMM_FRAC_MSB  10
`define IMM_PAD_W     20
// Shift count field.
`define CNT_W         7
// Page pointer.
`define PAGE_W        8
`define PAGE_SRC_MSB  7
`define DP_RESET      32'h0000_0000
// Register index limit of the extended-precision group.
`define EXT_REG_COUNT 5'h08
// Slow clock divider.
`define DIV_W         4
`define DIV_LAST      4'hf
// Addressing-mode codes.
`define MODE_REG      2'h0
`define MODE_DIRECT   2'h1
`define MODE_INDIRECT 2'h2
`define MODE_IMM      2'h3

`endif

// >>> core/shift_ops_pkg.sv
package shift_ops_pkg;
  `include "shift_ops_defines.svh"

  // Operations decoded ahead of this unit.
  typedef enum logic [2:0] {
    op_none,
    mantissa_load_op,
    page_pointer_load_op,
    slow_clock_op,
    full_rate_op,
    logical_shift_op,
    three_operand_shift_op
  } exec_op_t;

  // One decoded instruction with all operands already read.
  typedef struct packed {
    logic                 valid;
    exec_op_t             op;
    logic [1:0]           mode;
    logic [`IDX_W-1:0]    dst_idx;
    logic [`EXT_W-1:0]    reg_dst;
    logic [`EXT_W-1:0]    reg_src;
    logic [`EXT_W-1:0]    reg_cnt;
    logic [`WORD_W-1:0]   mem_src;
    logic [`WORD_W-1:0]   mem_cnt;
    logic [`IMM_W-1:0]    imm;
  } exec_req_t;

  // Condition flags.
  typedef struct packed {
    logic latched_underflow_flag;
    logic lv;
    logic uf;
    logic n;
    logic z;
    logic v;
    logic c;
  } cond_flags_t;
endpackage

// >>> testbench/shift_mantissa_page_power_ops_tb.sv
`timescale 1ns/1ps
`include "shift_ops_defines.svh"

// ****************************************
// Bench for the shift, mantissa, page and power unit.
// ****************************************
module shift_mantissa_page_power_ops_tb
  import shift_ops_pkg::*;
;
  // One table row: operands beside the write and flags they should give.
  typedef struct packed {
    exec_op_t    op;
    logic [1:0]  mode;
    logic [4:0]  idx;
    logic [39:0] dst;
    logic [39:0] src;
    logic [39:0] cnt;
    logic [31:0] msrc;
    logic [31:0] mcnt;
    logic [15:0] imm;
    logic [39:0] exp;
    logic        full;
    logic [2:0]  nzc;
  } row_t;

  logic                 i_clk;
  logic                 i_sys_rst;
  logic                 i_clk_en;
  exec_req_t            i_req;
  logic [15:0]          i_direct_disp;
  logic                 o_wr_valid;
  logic [4:0]           o_wr_idx;
  logic [39:0]          o_wr_data;
  cond_flags_t          o_flags;
  logic [31:0]          o_page_ptr;
  logic [23:0]          o_direct_addr;
  logic                 o_slow_mode;
  logic                 o_cycle_tick;
  row_t                 rows [16];
  cond_flags_t          exp_f;
  int                   error_cnt;
  int                   tests_run;
  int                   cycles;
  int                   n;

  shift_ops_exec dut (
    .i_clk         (i_clk),
    .i_sys_rst     (i_sys_rst),
    .i_clk_en      (i_clk_en),
    .i_req         (i_req),
    .i_direct_disp (i_direct_disp),
    .o_wr_valid    (o_wr_valid),
    .o_wr_idx      (o_wr_idx),
    .o_wr_data     (o_wr_data),
    .o_flags       (o_flags),
    .o_page_ptr    (o_page_ptr),
    .o_direct_addr (o_direct_addr),
    .o_slow_mode   (o_slow_mode),
    .o_cycle_tick  (o_cycle_tick)
  );

  // Free-running 200 MHz clock.
  always #2.5 i_clk = ~i_clk;

  // Cuts a hung run short.
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // Compares one value.
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares the condition flags.
  task automatic chk_flg(input cond_flags_t got, input cond_flags_t exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t flags got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Presents a request at the falling edge and waits past the accepting edge.
  task automatic send(input row_t r);
    i_req = '{1'b1, r.op, r.mode, r.idx, r.dst, r.src, r.cnt, r.msrc, r.mcnt, r.imm};
    @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Main sequence.
  // ****************************************
  initial
  begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_clk_en = 1'b1;
    i_req = '0;
    i_direct_disp = 16'h0000;
    exp_f = '0;
    rows = '{
      '{logical_shift_op, 2'h3, 5'h07, 40'h2ac, 40'h0, 40'h0, 32'h0, 32'h0, 16'h0018, 40'hac000000, 1'b0, 3'h4},
      '{mantissa_load_op, 2'h3, 5'h02, 40'h5500000000, 40'h0, 40'h0, 32'h0, 32'h0, 16'h01cc, 40'h551cc00000, 1'b1, 3'h0},
      '{logical_shift_op, 2'h0, 5'h05, 40'h12c00000, 40'h0, 40'hfffffffff4, 32'h0, 32'h0, 16'h0, 40'h12c00, 1'b0, 3'h0},
      '{mantissa_load_op, 2'h0, 5'h01, 40'h3300000000, 40'h7712345678, 40'h0, 32'h0, 32'h0, 16'h0, 40'h3312345678, 1'b1, 3'h0},
      '{logical_shift_op, 2'h1, 5'h00, 40'hffffffff, 40'h0, 40'h0, 32'h0, 32'h80, 16'h0, 40'hffffffff, 1'b0, 3'h4},
      '{mantissa_load_op, 2'h1, 5'h03, 40'h0100000000, 40'h0, 40'h0, 32'hdeadbeef, 32'h0, 16'h0, 40'h01deadbeef, 1'b1, 3'h0},
      '{logical_shift_op, 2'h2, 5'h04, 40'h80000001, 40'h0, 40'h0, 32'h0, 32'h1, 16'h0, 40'h2, 1'b0, 3'h1},
      '{mantissa_load_op, 2'h2, 5'h06, 40'h0, 40'h0, 40'h0, 32'h80000000, 32'h0, 16'h0, 40'h80000000, 1'b1, 3'h0},
      '{logical_shift_op, 2'h3, 5'h06, 40'h3, 40'h0, 40'h0, 32'h0, 32'h0, 16'h007f, 40'h1, 1'b0, 3'h1},
      '{logical_shift_op, 2'h3, 5'h01, 40'h3, 40'h0, 40'h0, 32'h0, 32'h0, 16'h001f, 40'h80000000, 1'b0, 3'h5},
      '{logical_shift_op, 2'h3, 5'h02, 40'hffffffff, 40'h0, 40'h0, 32'h0, 32'h0, 16'h0040, 40'h0, 1'b0, 3'h2},
      '{three_operand_shift_op, 2'h0, 5'h00, 40'hffff, 40'h2ac, 40'h18, 32'h1, 32'h1, 16'h0, 40'hac000000, 1'b0, 3'h4},
      '{three_operand_shift_op, 2'h1, 5'h01, 40'h0, 40'h1, 40'hfffffffff4, 32'h12c00000, 32'h1, 16'h0, 40'h12c00, 1'b0, 3'h0},
      '{three_operand_shift_op, 2'h2, 5'h02, 40'h0, 40'h1, 40'h1, 32'h7, 32'h4, 16'h0, 40'h10, 1'b0, 3'h0},
      '{three_operand_shift_op, 2'h3, 5'h03, 40'h5, 40'h1, 40'h1, 32'h0, 32'h5, 16'h0, 40'h0, 1'b0, 3'h2},
      '{logical_shift_op, 2'h3, 5'h09, 40'h1, 40'h0, 40'h0, 32'h0, 32'h0, 16'h0001, 40'h2, 1'b0, 3'h0}};
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'b0;
    // Table rows, issued back to back.
    foreach (rows[i])
    begin
      send(rows[i]);
      chk(40'(o_wr_valid), 40'h1);
      chk(40'(o_wr_idx), 40'(rows[i].idx));
      if (rows[i].full)
        chk(o_wr_data, rows[i].exp);
      else
        chk(40'(o_wr_data[31:0]), rows[i].exp);
      if (rows[i].op != mantissa_load_op && rows[i].idx < `EXT_REG_COUNT)
        exp_f = {3'h0, rows[i].nzc[2:1], 1'b0, rows[i].nzc[0]};
      chk_flg(o_flags, exp_f);
    end
    i_req.valid = 1'b0;
    @(negedge i_clk);
    chk(40'(o_wr_valid), 40'h0);
    // A request with the clock enable low is ignored.
    i_clk_en = 1'b0;
    send(rows[0]);
    i_req.valid = 1'b0;
    i_clk_en = 1'b1;
    chk(40'(o_wr_valid), 40'h0);
    // Page pointer load and the direct address built from it.
    send(row_t'{op: page_pointer_load_op, mode: 2'h3, imm: 16'h0980, default: '0});
    i_req.valid = 1'b0;
    i_direct_disp = 16'h9900;
    chk(40'(o_page_ptr), 40'h80);
    chk(40'(o_wr_valid), 40'h0);
    repeat (2) @(negedge i_clk);
    chk(40'(o_direct_addr), 40'h809900);
    // Slow mode: one slot in sixteen, then back to full rate.
    send(row_t'{op: slow_clock_op, default: '0});
    chk(40'(o_slow_mode), 40'h1);
    i_req.op = full_rate_op;
    n = 0;
    while (o_cycle_tick === 1'b0 && n < 40)
    begin
      n++;
      @(negedge i_clk);
    end
    chk(40'(n), 40'h0f);
    @(negedge i_clk);
    i_req.valid = 1'b0;
    chk(40'(o_slow_mode), 40'h0);
    chk(40'(o_cycle_tick), 40'h1);
    chk_flg(o_flags, exp_f);
    // Reset in mid-run, entered from slow mode.
    send(row_t'{op: slow_clock_op, default: '0});
    i_req.valid = 1'b0;
    i_sys_rst = 1'b1;
    #1;
    chk(o_wr_data, 40'h0);
    chk(40'(o_page_ptr), 40'h0);
    chk(40'(o_direct_addr), 40'h0);
    chk(40'({o_wr_valid, o_slow_mode, o_cycle_tick, o_wr_idx}), 40'h20);
    chk_flg(o_flags, '0);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    exp_f = '0;
    // First request right after release is taken.
    send(rows[0]);
    i_req.valid = 1'b0;
    chk(40'(o_wr_data[31:0]), rows[0].exp);
    end_of_test();
  end
endmodule
